// ---- include/flash_host_pkg.sv ----
/*
  Constants shared by the flash command host: command words, address fields,
  page geometry and cycle spacing.
  Assumes a 32-bit word-store path to the flash and a 20 MHz system clock.
*/
package flash_host_pkg;

	// ----------------------------------------------------------------
	// Operations requested by the user side.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_READ, OP_RESET, OP_PROG} op_t;

	// ----------------------------------------------------------------
	// Command words and unlock cycle addresses.
	// ----------------------------------------------------------------
	localparam logic [31:0] CMD_WORD_READ  = 32'h0000_00F0;
	localparam logic [31:0] UNLOCK_DATA_1  = 32'h0000_00AA;
	localparam logic [31:0] UNLOCK_DATA_2  = 32'h0000_0055;
	localparam logic [31:0] CMD_WORD_PROG  = 32'h0000_00A0;
	localparam logic [18:0] UNLOCK_OFS_1   = 19'h0_5554;
	localparam logic [18:0] UNLOCK_OFS_2   = 19'h0_AAA8;

	// ----------------------------------------------------------------
	// Address fields.
	// ----------------------------------------------------------------
	localparam int          REGION_LSB     = 21;
	localparam int          CHIP_LSB       = 19;
	localparam int          PAGE_LSB       = 9;
	localparam logic [1:0]  CHIP_0         = 2'h0;
	localparam logic [1:0]  CHIP_1         = 2'h2;
	localparam logic [8:0]  PAGE_TOP_OFS   = 9'h000;

	// ----------------------------------------------------------------
	// Sequence lengths and spacing.
	// ----------------------------------------------------------------
	localparam logic [7:0]  UNLOCK_STEPS   = 8'h03;
	localparam logic [7:0]  PAGE_WORDS     = 8'h80;
	localparam logic [7:0]  PROG_STEPS     = 8'h83;
	localparam logic [7:0]  READ_STEPS     = 8'h02;
	localparam logic [7:0]  RESET_STEPS    = 8'h03;
	localparam int          GAP_CYCLES     = 15;
	localparam logic [3:0]  GAP_LOAD       = 4'(GAP_CYCLES - 1);

endpackage

// ---- core/flash_cmd_host.sv ----
/*
  Host-side command sequencer for an on-chip flash: issues read, read/reset
  and page program sequences as spaced word-store bus write cycles.
  Assumes the flash ready/busy flag arrives asynchronously and that the
  user keeps one request per completion and supplies 128 words per page.
*/
`timescale 1ns/100ps

// What this block does
// - Read command writes F0 word once to chip 0 and chip 1.
// - Host cancels a program sequence still busy after WAIT_LIMIT cycles with the read/reset command.
// - Address bits 20 to 19 stay fixed to select the chip in program and reset commands.
// - Address bits 31 to 21 equal the region where commands run.
// - Command write cycles are spaced at least 15 clocks apart.
// - Host makes no flash loads, DMA, jumps or interrupts between cycles.
// - Each store is followed by a barrier; code runs outside flash.
// - Host checks ready/busy is one before the first write cycle, except for read/reset.
// - Programming only clears bits; each erased page programmed once.
// - Fourth cycle gives page top and first word; later words follow.
// - Host writes a whole page, unchanged words as all ones.
// - One program command writes exactly one page, never crossing it.
module flash_cmd_host
	import flash_host_pkg::*;
#(
	parameter int unsigned WAIT_LIMIT = 100000
)(
	// Clock and reset.
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// User request.
	input  wire logic                  req_valid,
	input  wire flash_host_pkg::op_t   req_op,
	input  wire logic [31:0]           req_addr,
	output logic                       req_ready,
	// Page data stream.
	input  wire logic                  wr_valid,
	input  wire logic [31:0]           wr_data,
	output logic                       wr_ready,
	// Flash bus write cycles.
	output logic                       bus_wr,
	output logic [31:0]                bus_addr,
	output logic [31:0]                bus_wdata,
	// Flash status pin.
	input  wire logic                  ready_busy_flag,
	// Completion.
	output logic                       busy,
	output logic                       done,
	output logic                       error
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_ISSUE, ST_GAP, ST_WAIT} state_t;

	state_t        state;
	op_t           op;
	logic [31:0]   base;
	logic [7:0]    step;
	logic [3:0]    gap;
	logic [19:0]   wait_cnt;
	logic          failed;
	logic          rb_meta;
	logic          rb;
	logic [31:0]   fifo_mem [2];
	logic          fifo_wptr;
	logic          fifo_rptr;
	logic [1:0]    fifo_cnt;

	// ----------------------------------------------------------------
	// Status pin synchroniser.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		rb_meta <= rst_n ? ready_busy_flag : 1'b0;
		rb      <= rst_n ? rb_meta : 1'b0;
	end

	// ----------------------------------------------------------------
	// Sequence decode.
	// ----------------------------------------------------------------
	localparam logic [19:0] WAIT_LOAD = 20'(WAIT_LIMIT - 1);

	wire         data_step  = (op == OP_PROG) && (step >= UNLOCK_STEPS);
	wire  [7:0]  word_idx   = step - UNLOCK_STEPS;
	wire  [8:0]  word_ofs   = {word_idx[6:0], 2'b00};
	wire  [1:0]  chip       = (op == OP_READ) ? ((step == 8'h00) ? CHIP_0 : CHIP_1)
	                                          : base[CHIP_LSB+1:CHIP_LSB];
	wire  [18:0] unlock_ofs = (step == 8'h01) ? UNLOCK_OFS_2 : UNLOCK_OFS_1;
	wire  [31:0] unlock_dat = (step == 8'h00) ? UNLOCK_DATA_1 :
	                          (step == 8'h01) ? UNLOCK_DATA_2 :
	                          (op == OP_PROG) ? CMD_WORD_PROG : CMD_WORD_READ;
	wire  [31:0] seq_addr   = data_step
	                          ? {base[31:PAGE_LSB], word_ofs}
	                          : (op == OP_READ)
	                          ? {base[31:REGION_LSB], chip, 19'h0_0000}
	                          : {base[31:REGION_LSB], chip, unlock_ofs};
	wire  [31:0] seq_data   = data_step ? fifo_mem[fifo_rptr]
	                          : (op == OP_READ) ? CMD_WORD_READ : unlock_dat;
	wire  [7:0]  last_step  = (op == OP_PROG) ? PROG_STEPS :
	                          (op == OP_READ) ? READ_STEPS : RESET_STEPS;
	wire         can_issue  = !data_step || (fifo_cnt != 2'h0);
	wire         fire       = (state == ST_ISSUE) && can_issue;
	wire         pop        = fire && data_step;
	wire         push       = wr_valid && wr_ready;
	wire  [1:0]  next_cnt   = 2'(fifo_cnt + {1'b0, push} - {1'b0, pop});
	wire         accept     = req_valid && req_ready;

	// ----------------------------------------------------------------
	// Two-entry word buffer.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (push)
			fifo_mem[fifo_wptr] <= wr_data;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			fifo_wptr <= 1'b0;
			fifo_rptr <= 1'b0;
			fifo_cnt  <= 2'h0;
			wr_ready  <= 1'b0;
		end
		else
		begin
			fifo_wptr <= fifo_wptr ^ push;
			fifo_rptr <= fifo_rptr ^ pop;
			fifo_cnt  <= next_cnt;
			wr_ready  <= (next_cnt != 2'h2);
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state     <= ST_IDLE;
			op        <= OP_READ;
			base      <= 32'h0000_0000;
			step      <= 8'h00;
			gap       <= 4'h0;
			wait_cnt  <= 20'h0_0000;
			failed    <= 1'b0;
			req_ready <= 1'b0;
			bus_wr    <= 1'b0;
			bus_addr  <= 32'h0000_0000;
			bus_wdata <= 32'h0000_0000;
			busy      <= 1'b0;
			done      <= 1'b0;
			error     <= 1'b0;
		end
		else
		begin
			bus_wr <= 1'b0;
			done   <= 1'b0;
			error  <= 1'b0;
			unique case (state)
				ST_IDLE:
				begin
					req_ready <= !accept;
					busy      <= accept;
					if (accept)
					begin
						op       <= req_op;
						base     <= req_addr;
						step     <= 8'h00;
						failed   <= 1'b0;
						wait_cnt <= WAIT_LOAD;
						state    <= ST_CHECK;
					end
				end
				ST_CHECK:
				begin
					wait_cnt <= wait_cnt - 20'h0_0001;
					if (rb || op == OP_RESET)
						state <= ST_ISSUE;
					else if (wait_cnt == 20'h0_0000)
					begin
						error     <= 1'b1;
						busy      <= 1'b0;
						req_ready <= 1'b1;
						state     <= ST_IDLE;
					end
				end
				ST_ISSUE:
				begin
					if (can_issue)
					begin
						bus_wr    <= 1'b1;
						bus_addr  <= seq_addr;
						bus_wdata <= seq_data;
						step      <= step + 8'h01;
						gap       <= GAP_LOAD;
						state     <= ST_GAP;
					end
				end
				ST_GAP:
				begin
					gap      <= gap - 4'h1;
					wait_cnt <= WAIT_LOAD;
					if (gap == 4'h0)
					begin
						if (step != last_step)
							state <= ST_ISSUE;
						else if (op == OP_PROG)
							state <= ST_WAIT;
						else
						begin
							done      <= !failed;
							error     <= failed;
							busy      <= 1'b0;
							req_ready <= 1'b1;
							state     <= ST_IDLE;
						end
					end
				end
				ST_WAIT:
				begin
					wait_cnt <= wait_cnt - 20'h0_0001;
					if (rb)
					begin
						done      <= 1'b1;
						busy      <= 1'b0;
						req_ready <= 1'b1;
						state     <= ST_IDLE;
					end
					else if (wait_cnt == 20'h0_0000)
					begin
						op     <= OP_RESET;
						step   <= 8'h00;
						failed <= 1'b1;
						state  <= ST_ISSUE;
					end
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	// Counts quiet cycles since the last write cycle, saturating at its top value.
	logic [3:0]    wr_quiet;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			wr_quiet <= 4'hF;
		else if (bus_wr)
			wr_quiet <= 4'h0;
		else if (wr_quiet != 4'hF)
			wr_quiet <= wr_quiet + 4'h1;
	end

	a_write_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr |-> wr_quiet >= GAP_LOAD)
		else $error("Bus write cycles closer than the minimum spacing.");

	a_read_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && op == OP_READ |-> bus_wdata == CMD_WORD_READ)
		else $error("Read command carries a wrong data word.");

	a_read_chips: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && op == OP_READ |-> bus_addr[20:19] == ((step == 8'h01) ? CHIP_0 : CHIP_1))
		else $error("Read command does not address both chips in order.");

	a_region_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr |-> bus_addr[31:21] == base[31:21])
		else $error("Command cycle left the execution region.");

	a_chip_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && op != OP_READ |-> bus_addr[20:19] == base[20:19])
		else $error("Chip select bits changed inside a command.");

	a_ready_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_CHECK && op != OP_RESET && !rb |=> state != ST_ISSUE)
		else $error("First cycle started while the flash was busy.");

	a_page_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && op == OP_PROG && step == 8'h04 |-> bus_addr[8:0] == PAGE_TOP_OFS)
		else $error("Fourth cycle is not the page top address.");

	a_page_walk: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && op == OP_PROG && step > UNLOCK_STEPS
		|-> bus_addr[31:9] == base[31:9] && bus_addr[8:0] == 9'({word_idx[6:0] - 7'h01, 2'b00}))
		else $error("Program word left its page or sequence.");

	a_page_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && op == OP_PROG |-> step <= PROG_STEPS)
		else $error("More words written than one page holds.");

	a_fail_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_WAIT && !rb && wait_cnt == 20'h0_0000
		|=> state == ST_ISSUE && op == OP_RESET ##[1:2] bus_wr)
		else $error("Locked flash not released with read/reset.");

endmodule

// ---- dv/flash_dev_model.sv ----
/*
  Behavioural flash device behind the command host: decodes word-store cycles,
  programs one page per command and drives the ready/busy pin.
  Assumes one bus_wr pulse per cycle from the host, on clk_sys.
*/
`timescale 1ns/100ps
module flash_dev_model
(
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Word-store cycles.
	input  wire logic        bus_wr,
	input  wire logic [31:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	// Makes the next page fail.
	input  wire logic        fail,
	// Status pin.
	output logic             ready_busy_flag
);
	import flash_host_pkg::*;
	// ----------------------------------------------------------------
	// Command decode and page programming.
	// ----------------------------------------------------------------
	logic [31:0] page_addr [128];
	logic [31:0] page_data [128];
	logic [1:0]  step;
	logic        locked;
	int          idx, hold, since, n_gap_err, n_page_err;
	wire logic [18:0] ofs = bus_addr[18:0];
	wire logic        prog = step == 2'h3;
	// Busy during any automatic operation, locked failures too.
	assign ready_busy_flag = !locked && hold == 0 && !(prog && idx != 0);
	always_ff @(posedge clk_sys)
	begin
		since <= bus_wr ? 0 : since + 1;
		if (hold != 0)
			hold <= hold - 1;
		if (!rst_n)
		begin
			// Reset aborts everything and gives read mode.
			step <= 2'h0;
			locked <= 1'b0;
			idx <= 0;
			hold <= 0;
			since <= 99;
		end
		else if (bus_wr)
		begin
			if (since + 1 < GAP_CYCLES)
				n_gap_err <= n_gap_err + 1;
			if (prog)
			begin
				// Words fill one page only; reset command ignored.
				if (idx != 0 && bus_addr[31:9] != page_addr[0][31:9])
					n_page_err <= n_page_err + 1;
				page_addr[idx] <= bus_addr;
				page_data[idx] <= bus_wdata;
				idx <= idx == 127 ? 0 : idx + 1;
				if (idx == 127)
					step <= 2'h0;
				if (idx == 127 && fail)
					locked <= 1'b1;
				else if (idx == 127)
					hold <= 20;
			end
			else if (bus_wdata == UNLOCK_DATA_1 && ofs == UNLOCK_OFS_1)
				step <= 2'h1;
			else if (step == 2'h1 && bus_wdata == UNLOCK_DATA_2 && ofs == UNLOCK_OFS_2)
				step <= 2'h2;
			else if (step == 2'h2 && bus_wdata == CMD_WORD_PROG && ofs == UNLOCK_OFS_1 && !locked)
				step <= 2'h3;
			else
			begin
				// Mismatch aborts; third reset cycle unlocks.
				step <= 2'h0;
				if (step == 2'h2 && bus_wdata == CMD_WORD_READ)
					locked <= 1'b0;
			end
		end
	end
endmodule

// ---- dv/flash_command_sequencer_tb.sv ----
/*
  Self-checking bench for the flash command host against the flash model.
  Assumes WAIT_LIMIT 64 and a model page time well under that.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("[FAIL] %s expected %h seen %h", nm, exp, got); \
		end \
	end
module flash_command_sequencer_tb;
	import flash_host_pkg::*;
	// ----------------------------------------------------------------
	// Signals, table and instances.
	// ----------------------------------------------------------------
	logic        clk_sys, rst_n, req_valid, wr_valid, fail, got_done, got_err;
	op_t         req_op;
	logic [31:0] req_addr, wr_data, bus_addr, bus_wdata;
	logic        req_ready, wr_ready, bus_wr, ready_busy_flag, busy, done, error;
	int          n_mismatch, comparisons;
	typedef struct {op_t op; logic [31:0] addr; logic [31:0] last;} row_t;
	row_t rows [4] = '{'{OP_READ, 32'hBFE0_0000, 32'hBFF0_0000},
		'{OP_RESET, 32'hBFE0_0000, 32'hBFE0_5554}, '{OP_RESET, 32'h4010_0000, 32'h4010_5554},
		'{OP_READ, 32'h0020_0000, 32'h0030_0000}};
	flash_cmd_host #(.WAIT_LIMIT(64)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_ready(req_ready),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .bus_wr(bus_wr),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .ready_busy_flag(ready_busy_flag),
		.busy(busy), .done(done), .error(error));
	flash_dev_model model (.clk_sys(clk_sys), .rst_n(rst_n), .bus_wr(bus_wr),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .fail(fail),
		.ready_busy_flag(ready_busy_flag));
	// ----------------------------------------------------------------
	// Tasks.
	// ----------------------------------------------------------------
	task finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task run_req(input op_t op, input logic [31:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		do @(negedge clk_sys); while (req_ready !== 1'b1);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		got_done = 1'b0;
		got_err = 1'b0;
		while (!got_done && !got_err && n < 6000)
		begin
			@(negedge clk_sys);
			got_done = done === 1'b1;
			got_err = error === 1'b1;
			n++;
		end
	endtask
	task push(input logic [31:0] w);
		wr_valid <= 1'b1;
		wr_data <= w;
		do @(negedge clk_sys); while (wr_ready !== 1'b1);
		@(posedge clk_sys);
	endtask
	task prog_page(input logic [31:0] page, input logic [31:0] w0, input logic bad);
		fail <= bad;
		@(posedge clk_sys);
		push(w0);
		push(32'hC000_0001);
		@(negedge clk_sys);
		`CHK("wr_ready full", 1'b0, wr_ready)
		@(posedge clk_sys);
		fork
			run_req(OP_PROG, page);
			for (int i = 2; i < 128; i++)
			begin
				push(32'hC000_0000 | 32'(i));
				if (i % 8 == 7)
				begin
					wr_valid <= 1'b0;
					@(posedge clk_sys);
				end
			end
			begin
				repeat (40) @(negedge clk_sys);
				`CHK("req_ready busy", 2'h1, {req_ready, busy})
			end
		join
		wr_valid <= 1'b0;
		`CHK("done", !bad, got_done)
		`CHK("error", bad, got_err)
		`CHK("flag after", 1'b1, ready_busy_flag)
		for (int i = 0; i < 128; i++)
		begin
			`CHK("page addr", {page[31:9], 9'(i * 4)}, model.page_addr[i])
			`CHK("page data", i == 0 ? w0 : 32'hC000_0000 | 32'(i), model.page_data[i])
		end
		$display("test prog page %h done", page);
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence.
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial
	begin
		#1000000;
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		{rst_n, req_valid, wr_valid, fail, req_addr, wr_data} = '0;
		req_op = OP_READ;
		repeat (6) @(posedge clk_sys);
		`CHK("reset outputs", 5'h00, {req_ready, wr_ready, busy, bus_wr, done})
		rst_n <= 1'b1;
		for (int r = 0; r < 4; r++)
		begin
			run_req(rows[r].op, rows[r].addr);
			`CHK("row done", 2'h2, {got_done, got_err})
			`CHK("row addr", rows[r].last, bus_addr)
			`CHK("row data", CMD_WORD_READ, bus_wdata)
			$display("test row %0d done", r);
		end
		@(posedge clk_sys);
		req_valid <= 1'b1;
		repeat (10) @(posedge clk_sys);
		req_valid <= 1'b0;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		`CHK("midrun reset", 2'h0, {busy, bus_wr})
		@(negedge clk_sys);
		`CHK("after reset", 4'hD, {req_ready, wr_ready, busy, ready_busy_flag})
		$display("test midrun reset done");
		prog_page(32'hBFE0_0400, 32'hC000_0000, 1'b0);
		prog_page(32'hBFE0_0600, 32'hFFFF_FFFF, 1'b1);
		`CHK("gap errors", 0, model.n_gap_err)
		`CHK("page errors", 0, model.n_page_err)
		finish_test();
	end
endmodule
